// ==== logic/tsp_cfg.svh ====
// Constants for the touch sense power and calibration block.
// Assumes a 50 MHz clock and a 5-bit register address.
`ifndef TSP_CFG_SVH
`define TSP_CFG_SVH
`define TSP_NCH 6
`define TSP_CLK_KHZ 50000
`define TSP_CAL_MS 200
`define TSP_CYC_MS 35
`define TSP_IDEAL_BASE 16'h0c80
`define TSP_AVG_SHIFT 6
`define TSP_A_CTRL 5'h00
`define TSP_A_ACT_EN 5'h01
`define TSP_A_STB_EN 5'h02
`define TSP_A_ACT_CFG 5'h03
`define TSP_A_STB_CFG 5'h04
`define TSP_A_STB_THR 5'h05
`define TSP_A_CAL 5'h06
`define TSP_A_GSTAT 5'h07
`define TSP_A_TOUCH 5'h08
`define TSP_A_OOL 5'h09
`define TSP_A_RECAL 5'h0a
`define TSP_A_BVALID 5'h0b
`define TSP_A_STATE 5'h0c
`define TSP_A_THR0 5'h10
`define TSP_A_BASE0 5'h18
`define TSP_B_SB 0
`define TSP_B_DS 1
`define TSP_B_KEEP 2
`define TSP_B_ACF 0
`define TSP_B_BCO 1
`define TSP_F_SAMP 1:0
`define TSP_F_CYC 3:2
`define TSP_F_AVG 6:4
`define TSP_F_SENS 10:8
`endif

// ==== logic/tsp_pkg.sv ====
// Types shared by the touch sense block and its bench.
// Assumes tsp_cfg.svh holds the numeric constants.
package tsp_pkg;
  typedef enum logic [1:0] {TSP_ACTIVE, TSP_STANDBY, TSP_DEEP} tsp_pwr_t;
  typedef enum logic [2:0] {
    TSP_IDLE, TSP_PICK, TSP_ACAL, TSP_AWAIT, TSP_MEAS, TSP_MWAIT, TSP_REST
  } tsp_st_t;
  // Request to the analog front end
  typedef struct packed {
    logic [2:0] ch;
    logic [1:0] samp;
    logic [2:0] avg;
  } tsp_afe_t;
  // Answer of the front end
  typedef struct packed {
    logic [15:0] count;
    logic noise;
    logic rail;
  } tsp_res_t;
endpackage : tsp_pkg

// ==== logic/tsp_core.sv ====
// Power state, sensing cycle and calibration control of a six input
// touch controller. Assumes a front end that answers each go pulse
// with one done pulse, and a register master on the same clock.
`timescale 1ns/10ps
`include "tsp_cfg.svh"
module tsp_core
  import tsp_pkg::*;
#(
  parameter int CAL_TMO = `TSP_CAL_MS * `TSP_CLK_KHZ,
  parameter int CYC_UNIT = `TSP_CYC_MS * `TSP_CLK_KHZ
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic bus_active,
  output logic core_awake,
  output logic low_power,
  output tsp_pwr_t pwr_state,
  output logic acal_go,
  output logic meas_go,
  output tsp_afe_t afe_req,
  input wire logic acal_done,
  input wire logic meas_done,
  input wire tsp_res_t afe_res,
  output logic [5:0] touch,
  output logic touch_evt
);
  localparam int N = `TSP_NCH;
  // ****************************************
  // Register storage
  // ****************************************
  logic [2:0] ctrl_reg;
  logic [5:0] act_en_reg, stb_en_reg, cal_reg, cal_next;
  logic [10:0] act_cfg_reg, stb_cfg_reg;
  logic [7:0] stb_thr_reg;
  logic [1:0] gstat_reg, gstat_next;
  logic [5:0] ool_reg, ool_next, touch_reg, bval_reg;
  logic [2:0] recal_reg;
  logic [7:0] thr_reg [N];
  logic [15:0] base_reg [N];
  logic [21:0] acc_reg [N];
  logic [5:0] nacc_reg [N];
  // Bus register index of a per-input window, or N when outside
  function automatic logic [2:0] win_idx(input logic [4:0] a,
                                         input logic [4:0] w);
    logic [4:0] d;
    d = a - w;
    win_idx = (a >= w && d < 5'(N)) ? d[2:0] : 3'(N);
  endfunction : win_idx
  wire logic [2:0] thr_i = win_idx(addr, `TSP_A_THR0);
  wire logic [2:0] base_i = win_idx(addr, `TSP_A_BASE0);
  wire logic wr_ctrl = wr && addr == `TSP_A_CTRL;
  wire logic wr_cal = wr && addr == `TSP_A_CAL;
  wire logic wr_gst = wr && addr == `TSP_A_GSTAT;
  wire logic wr_ool = wr && addr == `TSP_A_OOL;
  // Plain control registers
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_reg <= 3'h0;
      act_en_reg <= 6'h3f;
      stb_en_reg <= 6'h00;
      act_cfg_reg <= 11'h000;
      stb_cfg_reg <= 11'h000;
      stb_thr_reg <= 8'h40;
      recal_reg <= 3'h0;
    end
    else if (wr)
    begin
      if (wr_ctrl) ctrl_reg <= wdata[2:0];
      if (addr == `TSP_A_ACT_EN) act_en_reg <= wdata[5:0];
      if (addr == `TSP_A_STB_EN) stb_en_reg <= wdata[5:0];
      if (addr == `TSP_A_ACT_CFG) act_cfg_reg <= wdata[10:0];
      if (addr == `TSP_A_STB_CFG) stb_cfg_reg <= wdata[10:0];
      if (addr == `TSP_A_STB_THR) stb_thr_reg <= wdata[7:0];
      if (addr == `TSP_A_RECAL) recal_reg <= wdata[2:0];
    end

  // Per-input thresholds, one flop group each
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_thr
      always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
          thr_reg[g] <= 8'h40;
        else if (wr && thr_i == 3'(g))
          thr_reg[g] <= wdata[7:0];
    end
  endgenerate
  // ****************************************
  // Power state
  // ****************************************
  // Bus activity is a pin: three flops, accept when last two agree
  logic s1_reg, s2_reg, s3_reg, act_reg;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      act_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= bus_active;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) act_reg <= s3_reg;
    end

  wire logic ds = ctrl_reg[`TSP_B_DS];
  wire logic sb = ctrl_reg[`TSP_B_SB];
  wire tsp_pwr_t pwr = ds ? TSP_DEEP : sb ? TSP_STANDBY : TSP_ACTIVE;
  wire logic is_act = pwr == TSP_ACTIVE;
  // Standby keeps scanning and events; deep scans nothing
  wire logic [5:0] en_cur = is_act ? act_en_reg :
                            pwr == TSP_STANDBY ? stb_en_reg : 6'h00;
  wire logic [10:0] cfg = is_act ? act_cfg_reg : stb_cfg_reg;
  wire logic [1:0] samp = cfg[`TSP_F_SAMP];
  assign core_awake = !ds || act_reg;
  assign pwr_state = pwr;
  // ****************************************
  // Calibration triggers
  // ****************************************
  logic por_reg;
  logic [5:0] en_prev_reg;
  logic [1:0] samp_prev_reg;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      por_reg <= 1'b1;
      en_prev_reg <= 6'h00;
      samp_prev_reg <= 2'h0;
    end
    else
    begin
      por_reg <= 1'b0;
      en_prev_reg <= en_cur;
      samp_prev_reg <= samp;
    end

  wire logic [5:0] newly = en_cur & ~en_prev_reg;
  wire logic [5:0] gone = en_prev_reg & ~en_cur;
  wire logic samp_chg = samp != samp_prev_reg && !por_reg;
  wire logic [5:0] auto_cal = newly |
                              ((por_reg || samp_chg) ? en_cur : 6'h00);
  // Ideal base and its 12.5 percent window
  wire logic [15:0] ideal = `TSP_IDEAL_BASE << samp;
  wire logic [15:0] tol = ideal >> 3;
  function automatic logic out_lim(input logic [15:0] b,
                                   input logic [15:0] id,
                                   input logic [15:0] t);
    out_lim = (b > id + t) || (b < id - t);
  endfunction : out_lim
  // ****************************************
  // Sensing cycle
  // ****************************************
  tsp_st_t st_reg, st_next;
  logic [2:0] ch_reg;
  logic [23:0] tmr_reg;
  logic [23:0] wait_reg;
  logic cal_ph_reg;
  logic [7:0] rc_cnt_reg;
  wire logic [23:0] tmr_load =
    24'(CYC_UNIT * (int'(cfg[`TSP_F_CYC]) + 1));
  wire logic ch_on = ch_reg < 3'(N) && en_cur[ch_reg];
  wire logic tmo = wait_reg >= 24'(CAL_TMO - 1);
  wire logic a_fail = afe_res.noise || afe_res.rail;
  wire logic [15:0] cur_base = base_reg[ch_reg];
  wire logic [16:0] delta = {1'b0, afe_res.count} - {1'b0, cur_base};
  wire logic [23:0] dscl = 24'(delta[15:0]) << cfg[`TSP_F_SENS];
  wire logic [7:0] thr = is_act ? thr_reg[ch_reg] : stb_thr_reg;
  wire logic hit = !delta[16] && dscl > 24'(thr);
  wire logic [7:0] rc_mask = 8'((9'h1 << recal_reg) - 9'h1);
  wire logic rc_slot = (rc_cnt_reg & rc_mask) == 8'h00;
  wire logic [21:0] acc_sum = acc_reg[ch_reg] + 22'(afe_res.count);
  wire logic [15:0] avg_base = 16'(acc_sum >> `TSP_AVG_SHIFT);
  wire logic m_ok = st_reg == TSP_MWAIT && meas_done;
  wire logic cal_end = m_ok && cal_ph_reg;
  wire logic cal_oob = out_lim(afe_res.count, ideal, tol);
  wire logic keep = ctrl_reg[`TSP_B_KEEP];
  wire logic rc_do = m_ok && !cal_ph_reg && !afe_res.noise && !hit
                     && rc_slot;
  wire logic rc_fin = rc_do && nacc_reg[ch_reg] == 6'h3f;
  wire logic rc_oob = rc_fin && out_lim(avg_base, ideal, tol);
  wire logic a_bad = st_reg == TSP_AWAIT &&
                     ((acal_done && a_fail) || tmo);
  // Next state of the scan machine
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      TSP_IDLE: if (!ds) st_next = TSP_PICK;
      TSP_PICK:
        if (ch_reg >= 3'(N))
          st_next = tmr_reg != 24'h0 ? TSP_REST : TSP_IDLE;
        else if (ch_on)
          st_next = cal_reg[ch_reg] ? TSP_ACAL : TSP_MEAS;
      TSP_ACAL: st_next = TSP_AWAIT;
      TSP_AWAIT:
        if (a_bad) st_next = TSP_PICK;
        else if (acal_done) st_next = TSP_MEAS;
      TSP_MEAS: st_next = TSP_MWAIT;
      TSP_MWAIT: if (meas_done) st_next = TSP_PICK;
      TSP_REST: if (tmr_reg == 24'h0) st_next = TSP_IDLE;
    endcase
    if (ds) st_next = TSP_IDLE;
  end
  // Scan position, cycle timer and calibration timeout
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      st_reg <= TSP_IDLE;
      ch_reg <= 3'h0;
      tmr_reg <= 24'h0;
      wait_reg <= 24'h0;
      cal_ph_reg <= 1'b0;
      rc_cnt_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      if (st_reg == TSP_IDLE)
      begin
        ch_reg <= 3'h0;
        tmr_reg <= tmr_load;
        rc_cnt_reg <= rc_cnt_reg + 8'h01;
      end
      else
      begin
        if (tmr_reg != 24'h0) tmr_reg <= tmr_reg - 24'h1;
        if ((st_reg == TSP_PICK && ch_reg < 3'(N) && !ch_on) ||
            a_bad || (st_reg == TSP_MWAIT && meas_done))
          ch_reg <= ch_reg + 3'h1;
      end
      wait_reg <= st_reg == TSP_AWAIT ? wait_reg + 24'h1 : 24'h0;
      if (st_reg == TSP_ACAL) cal_ph_reg <= 1'b1;
      else if (st_reg == TSP_PICK) cal_ph_reg <= 1'b0;
    end

  assign low_power = st_reg == TSP_REST;
  assign acal_go = st_reg == TSP_ACAL;
  assign meas_go = st_reg == TSP_MEAS;
  // Front end request held in flops
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      afe_req <= '0;
    else
      afe_req <= '{ch: ch_reg, samp: samp, avg: cfg[`TSP_F_AVG]};
  // ****************************************
  // Calibration and status flags
  // ****************************************
  // Setting always wins over a clear in the same cycle
  always_comb
  begin
    cal_next = cal_reg;
    gstat_next = gstat_reg;
    ool_next = ool_reg;
    if (wr_gst) gstat_next = gstat_reg & ~wdata[1:0];
    if (wr_ool) ool_next = ool_reg & ~wdata[5:0];
    if (cal_end && !(cal_oob && !keep))
      cal_next[ch_reg] = 1'b0;
    if (cal_end && cal_oob)
    begin
      ool_next[ch_reg] = 1'b1;
      gstat_next[`TSP_B_BCO] = 1'b1;
    end
    if (a_bad) gstat_next[`TSP_B_ACF] = 1'b1;
    if (rc_oob) cal_next[ch_reg] = 1'b1;
    cal_next = cal_next | auto_cal | (wr_cal ? wdata[5:0] : 6'h00);
  end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cal_reg <= 6'h00;
      gstat_reg <= 2'h0;
      ool_reg <= 6'h00;
    end
    else
    begin
      cal_reg <= cal_next;
      gstat_reg <= gstat_next;
      ool_reg <= ool_next;
    end

  // ****************************************
  // Base counts, averaging and touch status
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < N; i++)
      begin
        base_reg[i] <= 16'h0000;
        acc_reg[i] <= 22'h0;
        nacc_reg[i] <= 6'h00;
      end
      bval_reg <= 6'h00;
    end
    else if (cal_end)
    begin
      base_reg[ch_reg] <= afe_res.count;
      bval_reg[ch_reg] <= 1'b1;
      acc_reg[ch_reg] <= 22'h0;
      nacc_reg[ch_reg] <= 6'h00;
    end
    else if (st_reg == TSP_ACAL)
      bval_reg[ch_reg] <= 1'b0;
    else if (rc_do)
    begin
      // Running 64 sample sum, then the base jumps to the mean
      acc_reg[ch_reg] <= rc_fin ? 22'h0 : acc_sum;
      nacc_reg[ch_reg] <= nacc_reg[ch_reg] + 6'h01;
      if (rc_fin) base_reg[ch_reg] <= avg_base;
    end
  // Touches of inputs being switched off are dropped; others hold
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      touch_reg <= 6'h00;
      touch_evt <= 1'b0;
    end
    else
    begin
      touch_evt <= m_ok && !cal_ph_reg && !afe_res.noise && hit &&
                   !touch_reg[ch_reg];
      if (gone != 6'h00)
        touch_reg <= touch_reg & ~gone;
      else if (m_ok && !cal_ph_reg && !afe_res.noise)
        touch_reg[ch_reg] <= hit;
    end

  assign touch = touch_reg;
  // ****************************************
  // Read port, data one cycle after the strobe
  // ****************************************
  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    if (thr_i < 3'(N)) rd_mux = {8'h00, thr_reg[thr_i]};
    else if (base_i < 3'(N)) rd_mux = base_reg[base_i];
    else
      unique case (addr)
        `TSP_A_CTRL: rd_mux = {13'h0, ctrl_reg};
        `TSP_A_ACT_EN: rd_mux = {10'h0, act_en_reg};
        `TSP_A_STB_EN: rd_mux = {10'h0, stb_en_reg};
        `TSP_A_ACT_CFG: rd_mux = {5'h0, act_cfg_reg};
        `TSP_A_STB_CFG: rd_mux = {5'h0, stb_cfg_reg};
        `TSP_A_STB_THR: rd_mux = {8'h00, stb_thr_reg};
        `TSP_A_CAL: rd_mux = {10'h0, cal_reg};
        `TSP_A_GSTAT: rd_mux = {14'h0, gstat_reg};
        `TSP_A_TOUCH: rd_mux = {10'h0, touch_reg};
        `TSP_A_OOL: rd_mux = {10'h0, ool_reg};
        `TSP_A_RECAL: rd_mux = {13'h0, recal_reg};
        `TSP_A_BVALID: rd_mux = {10'h0, bval_reg};
        `TSP_A_STATE:
          rd_mux = {11'h0, low_power, core_awake, st_reg == TSP_IDLE, pwr};
        default: rd_mux = 16'h0000;
      endcase
  end
  // Zero outside the answer cycle, so stale data never looks fresh
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rdata <= 16'h0000;
    else
      rdata <= rd ? rd_mux : 16'h0000;
endmodule : tsp_core

// ==== test/tsp_afe_model.sv ====
// Behavioural front end that answers the touch core's go pulses.
// Assumes one request at a time; answers DLY cycles later.
`timescale 1ns/10ps
module tsp_afe_model
  import tsp_pkg::*;
#(
  parameter int DLY = 3
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic acal_go,
  input wire logic meas_go,
  input wire tsp_afe_t afe_req,
  input wire logic [15:0] level [6],
  input wire logic noise,
  input wire logic rail,
  output logic acal_done,
  output logic meas_done,
  output tsp_res_t afe_res
);
  // ********
  // Pad response
  // ********
  int cnt_reg;
  logic kind_reg;
  logic [2:0] ch_reg;
  // Result lines toggle between answers so stale data never looks valid
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      acal_done <= 1'b0;
      meas_done <= 1'b0;
      afe_res <= '0;
      cnt_reg <= 0;
      kind_reg <= 1'b0;
      ch_reg <= 3'h0;
    end
    else
    begin
      acal_done <= 1'b0;
      meas_done <= 1'b0;
      afe_res <= ~afe_res;
      if (acal_go || meas_go)
      begin
        cnt_reg <= DLY;
        kind_reg <= meas_go;
        ch_reg <= afe_req.ch;
      end
      else if (cnt_reg > 1)
        cnt_reg <= cnt_reg - 1;
      else if (cnt_reg == 1)
      begin
        cnt_reg <= 0;
        acal_done <= !kind_reg;
        meas_done <= kind_reg;
        afe_res <= {level[ch_reg], noise, rail};
      end
    end
endmodule : tsp_afe_model

// ==== test/tsp_core_assertions.sv ====
// Port checker for the touch core, bound from the bench.
// Assumes a front end answering no sooner than three cycles.
`timescale 1ns/10ps
`include "tsp_cfg.svh"
module tsp_core_assertions
  import tsp_pkg::*;
#(
  parameter int CAL_TMO = 50,
  parameter int CYC_UNIT = 100
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic bus_active,
  input wire logic core_awake,
  input wire logic low_power,
  input wire tsp_pwr_t pwr_state,
  input wire logic acal_go,
  input wire logic meas_go,
  input wire tsp_afe_t afe_req,
  input wire logic acal_done,
  input wire logic meas_done,
  input wire tsp_res_t afe_res,
  input wire logic [5:0] touch,
  input wire logic touch_evt
);
  // ********
  // Helper state
  // ********
  logic [1:0] ctrl_reg;
  int lp_reg;
  tsp_pwr_t exp_pwr;
  // Deep sleep outranks standby
  assign exp_pwr = ctrl_reg[1] ? TSP_DEEP :
                   (ctrl_reg[0] ? TSP_STANDBY : TSP_ACTIVE);
  // Control bit mirror and idle run length
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_reg <= 2'h0;
      lp_reg <= 0;
    end
    else
    begin
      if (wr && addr == `TSP_A_CTRL)
        ctrl_reg <= wdata[1:0];
      lp_reg <= low_power ? lp_reg + 1 : 0;
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_acal_ok;
    acal_done && !afe_res.noise && !afe_res.rail && pwr_state != TSP_DEEP;
  endsequence
  sequence s_quiet3;
    (!meas_go && !acal_go)[*3];
  endsequence
  AST_PWR_MAP: assert property (pwr_state == exp_pwr)
    else $error("power state differs from control bits");
  AST_DEEP_QUIET: assert property (pwr_state == TSP_DEEP &&
    $past(pwr_state) == TSP_DEEP |-> !acal_go && !meas_go)
    else $error("front end started in deep sleep");
  AST_WAKE: assert property ($rose(bus_active) |-> ##[1:4] core_awake)
    else $error("bus traffic did not wake the core");
  AST_RESLEEP: assert property (
    $fell(bus_active) && ctrl_reg[1] |-> ##[1:6] !core_awake)
    else $error("core stayed awake after traffic");
  AST_AWAKE: assert property (pwr_state != TSP_DEEP |-> core_awake)
    else $error("core asleep outside deep sleep");
  AST_LP_QUIET: assert property (low_power |-> !acal_go && !meas_go)
    else $error("front end started while idling");
  AST_LP_BOUND: assert property (lp_reg <= CYC_UNIT * 4)
    else $error("idle outlasted the longest cycle");
  AST_CAL_THEN_MEAS: assert property (s_acal_ok |-> ##[1:2] meas_go)
    else $error("no measurement after analog tuning");
  AST_ONE_AT_A_TIME: assert property (acal_go |=> s_quiet3)
    else $error("request issued before tuning answered");
  AST_EVT_CAUSE: assert property (touch_evt |-> $past(meas_done))
    else $error("touch event without a measurement");
  AST_EVT_ON_RISE: assert property (
    (touch & ~$past(touch)) != 6'h00 |-> touch_evt)
    else $error("new touch without event");
endmodule : tsp_core_assertions

// ==== test/tsp_core_test.sv ====
// Self-checking bench for the touch core over its register port.
// Assumes the core, its checker and the front end model compile first.
`timescale 1ns/10ps
`include "tsp_cfg.svh"
module tsp_core_test
  import tsp_pkg::*;
;
  // ********
  // Stimulus and instances
  // ********
  localparam int CAL_TMO = 50;
  localparam int CYC_UNIT = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic bus_active = 1'b0;
  logic noise = 1'b0;
  logic rail = 1'b0;
  logic [15:0] level [6] = '{default: 16'h0c80};
  logic [15:0] rdata;
  logic core_awake, low_power, acal_go, meas_go, acal_done, meas_done;
  logic [5:0] touch;
  logic touch_evt;
  tsp_pwr_t pwr_state;
  tsp_afe_t afe_req;
  tsp_res_t afe_res;
  int fails = 0;
  int comparisons = 0;
  logic [15:0] v;
  // Short timing parameters keep the run brief
  always #10 clk = ~clk;
  tsp_core #(.CAL_TMO(CAL_TMO), .CYC_UNIT(CYC_UNIT)) dut_u (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .bus_active(bus_active),
    .core_awake(core_awake), .low_power(low_power),
    .pwr_state(pwr_state), .acal_go(acal_go), .meas_go(meas_go),
    .afe_req(afe_req), .acal_done(acal_done), .meas_done(meas_done),
    .afe_res(afe_res), .touch(touch), .touch_evt(touch_evt));
  tsp_afe_model afe_u (
    .clk(clk), .rst_n(rst_n), .acal_go(acal_go), .meas_go(meas_go),
    .afe_req(afe_req), .level(level), .noise(noise), .rail(rail),
    .acal_done(acal_done), .meas_done(meas_done), .afe_res(afe_res));
  task automatic summarize;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic expect_rd(input string nm, input logic [4:0] a,
                           input logic [15:0] e);
    reg_rd(a);
    check(nm, e, v);
  endtask : expect_rd
  // Bounded poll; running out ends the run
  task automatic poll(input string nm, input logic [4:0] a,
                      input logic [15:0] m, input logic [15:0] e);
    int n;
    n = 0;
    do
    begin
      reg_rd(a);
      n++;
    end
    while ((v & m) !== e && n < 2000);
    check(nm, e, v & m);
    if ((v & m) !== e)
      summarize();
  endtask : poll
  task automatic test_end(input string nm);
    $display("test %s finished", nm);
  endtask : test_end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    expect_rd("base valid", `TSP_A_BVALID, 16'h0000);
    expect_rd("active enables", `TSP_A_ACT_EN, 16'h003f);
    expect_rd("standby thr", `TSP_A_STB_THR, 16'h0040);
    expect_rd("thr 5", `TSP_A_THR0 + 5'h05, 16'h0040);
    poll("cal request", `TSP_A_CAL, 16'h003f, 16'h0000);
    expect_rd("base valid", `TSP_A_BVALID, 16'h003f);
    expect_rd("base 3", `TSP_A_BASE0 + 5'h03, 16'h0c80);
    level[2] <= 16'h0d80;
    poll("touch", `TSP_A_TOUCH, 16'h003f, 16'h0004);
    poll("idle", `TSP_A_STATE, 16'h0010, 16'h0010);
    test_end("reset_touch");
    reg_wr(`TSP_A_STB_CFG, 16'h0000);
    reg_wr(`TSP_A_STB_EN, 16'h0001);
    reg_wr(`TSP_A_STB_THR, 16'h0080);
    reg_wr(`TSP_A_THR0, 16'h0200);
    reg_wr(`TSP_A_CTRL, 16'h0001);
    repeat (2) @(negedge clk);
    check("pwr", {14'h0, TSP_STANDBY}, {14'h0, pwr_state});
    check("touch pins", 16'h0000, {10'h0, touch});
    level[0] <= 16'h0d80;
    poll("standby touch", `TSP_A_TOUCH, 16'h003f, 16'h0001);
    level[0] <= 16'h0c80;
    level[2] <= 16'h0c80;
    reg_wr(`TSP_A_CTRL, 16'h0000);
    expect_rd("new enables", `TSP_A_CAL, 16'h003e);
    poll("cal request", `TSP_A_CAL, 16'h003f, 16'h0000);
    test_end("standby");
    reg_wr(`TSP_A_CTRL, 16'h0003);
    @(negedge clk);
    check("pwr", {14'h0, TSP_DEEP}, {14'h0, pwr_state});
    check("awake", 16'h0000, {15'h0, core_awake});
    @(posedge clk);
    bus_active <= 1'b1;
    repeat (4) @(posedge clk);
    expect_rd("control", `TSP_A_CTRL, 16'h0003);
    check("awake", 16'h0001, {15'h0, core_awake});
    @(posedge clk);
    bus_active <= 1'b0;
    repeat (8) @(negedge clk);
    check("awake", 16'h0000, {15'h0, core_awake});
    reg_wr(`TSP_A_CTRL, 16'h0000);
    poll("cal request", `TSP_A_CAL, 16'h003f, 16'h0000);
    test_end("deep_sleep");
    for (int i = 0; i < 2; i++)
    begin
      noise <= (i == 0);
      rail <= (i == 1);
      reg_wr(`TSP_A_CAL, 16'h0002);
      poll("cal fail", `TSP_A_GSTAT, 16'h0001, 16'h0001);
      expect_rd("cal kept", `TSP_A_CAL, 16'h0002);
      noise <= 1'b0;
      rail <= 1'b0;
      reg_wr(`TSP_A_GSTAT, 16'h0001);
      poll("cal done", `TSP_A_CAL, 16'h0002, 16'h0000);
      expect_rd("fail clear", `TSP_A_GSTAT, 16'h0000);
    end
    level[1] <= 16'h0e11;
    for (int k = 0; k < 2; k++)
    begin
      reg_wr(`TSP_A_CTRL, {13'h0, k[0], 2'h0});
      reg_wr(`TSP_A_CAL, 16'h0002);
      poll("limit bit", `TSP_A_OOL, 16'h003f, 16'h0002);
      poll("limit flag", `TSP_A_GSTAT, 16'h0002, 16'h0002);
      poll("cal repeat", `TSP_A_CAL, 16'h0002, {14'h0, !k[0], 1'b0});
      reg_wr(`TSP_A_OOL, 16'h0002);
      reg_wr(`TSP_A_GSTAT, 16'h0002);
    end
    level <= '{default: 16'h1900};
    reg_wr(`TSP_A_ACT_CFG, 16'h0001);
    poll("cal request", `TSP_A_CAL, 16'h003f, 16'h0000);
    expect_rd("limit bits", `TSP_A_OOL, 16'h0000);
    expect_rd("base 5", `TSP_A_BASE0 + 5'h05, 16'h1900);
    test_end("calibration");
    summarize();
  end
endmodule : tsp_core_test
bind tsp_core tsp_core_assertions #(
  .CAL_TMO(CAL_TMO), .CYC_UNIT(CYC_UNIT)) chk_u (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .bus_active(bus_active),
  .core_awake(core_awake), .low_power(low_power),
  .pwr_state(pwr_state), .acal_go(acal_go), .meas_go(meas_go),
  .afe_req(afe_req), .acal_done(acal_done), .meas_done(meas_done),
  .afe_res(afe_res), .touch(touch), .touch_evt(touch_evt));
